// ---- rtl/coc_params.svh ----
`ifndef COC_PARAMS_SVH
`define COC_PARAMS_SVH

// register byte offsets
`define COC_STAT_OFS 8'h20
`define COC_CTRL_OFS 8'h24
`define COC_INTEN_OFS 8'h04

// control register fields
`define COC_SRC_MSB 10
`define COC_SRC_LSB 9
`define COC_TLVL_BIT 7
`define COC_TRIGGER_SENSE_SELECT_MSB 6
`define COC_TRIGGER_SENSE_SELECT_LSB 5
`define COC_ILVL_BIT 4
`define COC_INTERRUPT_SENSE_SELECT_MSB 3
`define COC_INTERRUPT_SENSE_SELECT_LSB 2
`define COC_INV_BIT 1

// status and enable fields
`define COC_CURRENT_OUTPUT_VALUE_BIT 1
`define COC_INTEN_BIT 0

// reset values
`define COC_RST_BIT 1'b0
`define COC_RST_WORD 32'h0000_0000

`endif

// ---- rtl/coc_pkg.sv ----
package coc_pkg;

    // sensing mode of one output path
    typedef enum logic [1:0] {
        COC_SENSE_LEVEL = 2'h0,
        COC_SENSE_FALL = 2'h1,
        COC_SENSE_RISE = 2'h2,
        COC_SENSE_BOTH = 2'h3
    } coc_sense_t;

    // positive input source
    typedef enum logic [1:0] {
        COC_SRC_PIN = 2'h0,
        COC_SRC_FIRST_POS = 2'h1,
        COC_SRC_INT_REF = 2'h2,
        COC_SRC_RSVD = 2'h3
    } coc_src_t;

endpackage

// ---- rtl/coc_sense.sv ----
`timescale 1ns/1ps
`default_nettype none

module coc_sense (
    input wire logic cur_i,
    input wire logic prev_i,
    input wire coc_pkg::coc_sense_t sel_i,
    input wire logic lvl_i,
    output logic hit_o
);
    import coc_pkg::*;

    // level match or qualifying transition
    always_comb begin
        case (sel_i)
            COC_SENSE_LEVEL: hit_o = (cur_i == lvl_i);
            COC_SENSE_FALL: hit_o = prev_i & ~cur_i;
            COC_SENSE_RISE: hit_o = ~prev_i & cur_i;
            COC_SENSE_BOTH: hit_o = prev_i ^ cur_i;
            default: hit_o = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// ---- rtl/coc_top.sv ----
// Decided for this implementation: the strobed register port and the register offsets.
`include "coc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module coc_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic cmp_raw_i,
    output var coc_pkg::coc_src_t pos_src_sel_o,
    output logic irq_o,
    output logic adc_trig_o
);
    import coc_pkg::*;

    // control and enable register state
    coc_src_t src_sel;
    logic trig_lvl;
    coc_sense_t trig_sel;
    logic irq_lvl;
    coc_sense_t irq_sel;
    logic inv;
    logic inten;
    coc_src_t next_src_sel;
    logic next_trig_lvl;
    coc_sense_t next_trig_sel;
    logic next_irq_lvl;
    coc_sense_t next_irq_sel;
    logic next_inv;
    logic next_inten;

    // comparator path state
    logic sync1;
    logic sync2;
    logic cond_q;
    logic next_sync1;
    logic next_sync2;
    logic next_cond_q;
    logic cond;
    logic rst_q;
    logic next_rst_q;

    // outputs
    logic [31:0] next_rdata;
    logic next_irq;
    logic next_trig;
    logic irq_hit;
    logic trig_hit;
    logic wr_ctrl;
    logic wr_inten;

    assign wr_ctrl = wr_i && (addr_i == ADDR_W'(`COC_CTRL_OFS));
    assign wr_inten = wr_i && (addr_i == ADDR_W'(`COC_INTEN_OFS));

    // register writes
    always_comb begin
        next_src_sel = src_sel;
        next_trig_lvl = trig_lvl;
        next_trig_sel = trig_sel;
        next_irq_lvl = irq_lvl;
        next_irq_sel = irq_sel;
        next_inv = inv;
        next_inten = inten;
        if (wr_ctrl) begin
            if (coc_src_t'(wdata_i[`COC_SRC_MSB:`COC_SRC_LSB]) != COC_SRC_RSVD) begin
                next_src_sel = coc_src_t'(wdata_i[`COC_SRC_MSB:`COC_SRC_LSB]);
            end
            next_trig_lvl = wdata_i[`COC_TLVL_BIT];
            next_trig_sel = coc_sense_t'(wdata_i[`COC_TRIGGER_SENSE_SELECT_MSB:`COC_TRIGGER_SENSE_SELECT_LSB]);
            next_irq_lvl = wdata_i[`COC_ILVL_BIT];
            next_irq_sel = coc_sense_t'(wdata_i[`COC_INTERRUPT_SENSE_SELECT_MSB:`COC_INTERRUPT_SENSE_SELECT_LSB]);
            next_inv = wdata_i[`COC_INV_BIT];
        end
        if (wr_inten) begin
            next_inten = wdata_i[`COC_INTEN_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            src_sel <= COC_SRC_PIN;
            trig_lvl <= `COC_RST_BIT;
            trig_sel <= COC_SENSE_LEVEL;
            irq_lvl <= `COC_RST_BIT;
            irq_sel <= COC_SENSE_LEVEL;
            inv <= `COC_RST_BIT;
            inten <= `COC_RST_BIT;
        end else begin
            src_sel <= next_src_sel;
            trig_lvl <= next_trig_lvl;
            trig_sel <= next_trig_sel;
            irq_lvl <= next_irq_lvl;
            irq_sel <= next_irq_sel;
            inv <= next_inv;
            inten <= next_inten;
        end
    end

    assign cond = sync2 ^ inv;

    always_comb begin
        next_sync1 = cmp_raw_i;
        next_sync2 = sync1;
        next_cond_q = cond;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sync1 <= `COC_RST_BIT;
            sync2 <= `COC_RST_BIT;
            cond_q <= `COC_RST_BIT;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            cond_q <= next_cond_q;
        end
    end

    // reset seen one edge ago, keeps checks off the release edge
    always_comb begin
        next_rst_q = srst_i;
    end

    always_ff @(posedge clock_i) begin
        rst_q <= next_rst_q;
    end

    coc_sense u_trig_sense (
        .cur_i(cond),
        .prev_i(cond_q),
        .sel_i(trig_sel),
        .lvl_i(trig_lvl),
        .hit_o(trig_hit)
    );

    coc_sense u_irq_sense (
        .cur_i(cond),
        .prev_i(cond_q),
        .sel_i(irq_sel),
        .lvl_i(irq_lvl),
        .hit_o(irq_hit)
    );

    // read mux and event outputs
    always_comb begin
        next_rdata = `COC_RST_WORD;
        if (rd_i) begin
            case (addr_i)
                ADDR_W'(`COC_CTRL_OFS): begin
                    next_rdata[`COC_SRC_MSB:`COC_SRC_LSB] = src_sel;
                    next_rdata[`COC_TLVL_BIT] = trig_lvl;
                    next_rdata[`COC_TRIGGER_SENSE_SELECT_MSB:`COC_TRIGGER_SENSE_SELECT_LSB] = trig_sel;
                    next_rdata[`COC_ILVL_BIT] = irq_lvl;
                    next_rdata[`COC_INTERRUPT_SENSE_SELECT_MSB:`COC_INTERRUPT_SENSE_SELECT_LSB] = irq_sel;
                    next_rdata[`COC_INV_BIT] = inv;
                end
                ADDR_W'(`COC_STAT_OFS): begin
                    next_rdata[`COC_CURRENT_OUTPUT_VALUE_BIT] = cond;
                end
                ADDR_W'(`COC_INTEN_OFS): begin
                    next_rdata[`COC_INTEN_BIT] = inten;
                end
                default: begin
                    next_rdata = `COC_RST_WORD;
                end
            endcase
        end
        next_irq = irq_hit & inten;
        next_trig = trig_hit;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_o <= `COC_RST_WORD;
            irq_o <= `COC_RST_BIT;
            adc_trig_o <= `COC_RST_BIT;
            pos_src_sel_o <= COC_SRC_PIN;
        end else begin
            rdata_o <= next_rdata;
            irq_o <= next_irq;
            adc_trig_o <= next_trig;
            pos_src_sel_o <= next_src_sel;
        end
    end

    // checks on the block's own behaviour
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i || rst_q); // release edge still shows reset state

    sequence raw_high3_s;
        cmp_raw_i [*3];
    endsequence

    sequence trig_pulse_s;
        adc_trig_o ##1 !adc_trig_o;
    endsequence

    sequence ctrl_read_s;
        rd_i && (addr_i == ADDR_W'(`COC_CTRL_OFS));
    endsequence

    sequence stat_read_s;
        rd_i && (addr_i == ADDR_W'(`COC_STAT_OFS));
    endsequence

    src_select_a: assert property (
        wr_ctrl && (coc_src_t'(wdata_i[`COC_SRC_MSB:`COC_SRC_LSB]) != COC_SRC_RSVD)
        |=> pos_src_sel_o == $past(wdata_i[`COC_SRC_MSB:`COC_SRC_LSB]))
        else $error("source select not applied");

    src_reserved_a: assert property (
        wr_ctrl && (coc_src_t'(wdata_i[`COC_SRC_MSB:`COC_SRC_LSB]) == COC_SRC_RSVD)
        |=> $stable(pos_src_sel_o))
        else $error("reserved source value applied");

    trig_level_a: assert property (
        (trig_sel == COC_SENSE_LEVEL) |=> adc_trig_o == ($past(cond) == $past(trig_lvl)))
        else $error("level trigger wrong");

    trig_fall_a: assert property (
        (trig_sel == COC_SENSE_FALL) && cond_q && !cond |=> adc_trig_o)
        else $error("falling trigger missed");

    trig_rise_a: assert property (
        (trig_sel == COC_SENSE_RISE) && !cond_q && cond |=> adc_trig_o)
        else $error("rising trigger missed");

    trig_both_a: assert property (
        (trig_sel == COC_SENSE_BOTH) && (cond != cond_q) |=> adc_trig_o)
        else $error("either-edge trigger missed");

    trig_pulse_a: assert property (
        (trig_sel == COC_SENSE_FALL) && !wr_ctrl && cond_q && !cond |=> trig_pulse_s)
        else $error("falling trigger not one pulse");

    trig_quiet_a: assert property (
        (trig_sel != COC_SENSE_LEVEL) && (cond == cond_q) |=> !adc_trig_o)
        else $error("edge trigger without edge");

    irq_level_a: assert property (
        (irq_sel == COC_SENSE_LEVEL) && inten
        |=> irq_o == ($past(cond) == $past(irq_lvl)))
        else $error("level interrupt wrong");

    irq_rise_a: assert property (
        (irq_sel == COC_SENSE_RISE) && inten && !wr_ctrl && !cond_q && cond
        |=> irq_o ##1 !irq_o)
        else $error("rising interrupt not one pulse");

    irq_fall_a: assert property (
        (irq_sel == COC_SENSE_FALL) && inten && cond_q && !cond |=> irq_o)
        else $error("falling interrupt missed");

    irq_both_a: assert property (
        (irq_sel == COC_SENSE_BOTH) && inten && (cond != cond_q) |=> irq_o)
        else $error("either-edge interrupt missed");

    irq_quiet_a: assert property (
        (irq_sel != COC_SENSE_LEVEL) && (cond == cond_q) |=> !irq_o)
        else $error("edge interrupt without edge");

    invert_path_a: assert property (
        raw_high3_s |-> cond == !inv)
        else $error("inversion wrong");

    rsvd_zero_a: assert property (
        ctrl_read_s |=> (rdata_o[31:11] == 21'h0) && !rdata_o[8] && !rdata_o[0])
        else $error("reserved bits not zero");

    irq_gate_a: assert property (
        !inten |=> !irq_o)
        else $error("interrupt passed while disabled");

    status_read_a: assert property (
        stat_read_s |=> rdata_o == {30'h0, $past(cond), 1'b0})
        else $error("status read wrong");

    sync_delay_a: assert property (
        $rose(cmp_raw_i) |-> ##2 $rose(sync2))
        else $error("edge path not synchronised");

endmodule

`default_nettype wire

// ---- verif/coc_cmp_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module coc_cmp_model (
    input wire logic level_i,
    output logic cmp_o
);
    // analog output settles a few ns after the inputs move, unrelated to the clock
    assign #3 cmp_o = level_i;
endmodule

`default_nettype wire

// ---- verif/coc_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module coc_top_tb_top;
    import coc_pkg::*;
    logic clock_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, lvl = 1'b0, cmp_raw_i;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, got, w, keep;
    logic irq_o, adc_trig_o, s1, s2, s3, eirq, etrg, inv, ilvl, tlvl, en;
    logic [1:0] interrupt_sense_select, trigger_sense_select;
    coc_src_t pos_src_sel_o;
    int fail_count = 0, n_tests = 0;

    coc_top i_dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .cmp_raw_i(cmp_raw_i),
        .pos_src_sel_o(pos_src_sel_o), .irq_o(irq_o), .adc_trig_o(adc_trig_o));
    coc_cmp_model i_cmp (.level_i(lvl), .cmp_o(cmp_raw_i));

    initial begin
        forever #4 clock_i = ~clock_i;
    end

    // expected sensing result for one path
    function automatic logic hit(logic c, logic p, logic [1:0] sel, logic l);
        case (sel)
            2'h0: return c == l;
            2'h1: return p & ~c;
            2'h2: return c & ~p;
            default: return c ^ p;
        endcase
    endfunction

    // reference pipeline: two sync stages, previous value, registered event
    always_ff @(posedge clock_i) begin
        s1 <= cmp_raw_i;
        s2 <= s1;
        s3 <= s2;
        eirq <= hit(s2 ^ inv, s3 ^ inv, interrupt_sense_select, ilvl) & en;
        etrg <= hit(s2 ^ inv, s3 ^ inv, trigger_sense_select, tlvl);
    end

    task automatic chk_word(string name, logic [31:0] exp, logic [31:0] seen);
        n_tests++;
        if (exp !== seen) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_bit(string name, logic exp, logic seen);
        chk_word(name, {31'h0, exp}, {31'h0, seen});
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        tally_and_finish();
    end

    initial begin
        {inv, ilvl, tlvl, en, interrupt_sense_select, trigger_sense_select} = '0;
        void'($urandom(76));
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
        // reset values and an unmapped place
        rd(8'h24);
        chk_word("ctrl reset", 32'h0, got);
        rd(8'h04);
        chk_word("enable reset", 32'h0, got);
        wr(8'h10, 32'hffff_ffff);
        rd(8'h10);
        chk_word("unmapped", 32'h0, got);
        // source select, reserved bits, refused source code
        keep = 32'h0;
        for (int i = 0; i < 8; i++) begin
            w = $urandom;
            w[10:9] = i[1:0];
            wr(8'h24, w);
            if (i[1:0] != 2'h3)
                keep = w & 32'h0000_06fe;
            else
                keep = (keep & 32'h0000_0600) | (w & 32'h0000_00fe);
            rd(8'h24);
            chk_word("ctrl readback", keep, got);
            chk_word("source", {30'h0, keep[10:9]}, {30'h0, pos_src_sel_o});
        end
        // every sense code on both paths, random levels and invert
        for (int m = 0; m < 16; m++) begin
            w = $urandom & 32'h0000_0092;
            w[3:2] = m[1:0];
            w[6:5] = m[3:2];
            wr(8'h24, w);
            wr(8'h04, {31'h0, m % 3 != 0});
            {tlvl, trigger_sense_select, ilvl, interrupt_sense_select, inv} = w[7:1];
            en = m % 3 != 0;
            repeat (6) @(posedge clock_i);
            rd(8'h20);
            chk_word("status", {30'h0, lvl ^ inv, 1'b0}, got);
            for (int k = 0; k < 40; k++) begin
                @(posedge clock_i);
                if ($urandom % 2)
                    lvl <= ~lvl;
                #1;
                chk_bit("irq", eirq, irq_o);
                chk_bit("trigger", etrg, adc_trig_o);
            end
        end
        tally_and_finish();
    end
endmodule

`default_nettype wire
